/* File: verilog/cpag_pkg.sv */
// package: constants and types of the code protection access gate
`default_nettype none
package cpag_pkg;
	// ************
	// address map
	// ************
	localparam logic [21:0] CPAG_ID_BASE   = 22'h20_0000; // eight id bytes
	localparam logic [21:0] CPAG_CFG_BASE  = 22'h30_0000; // config words
	localparam logic [21:0] CPAG_DEVID_ADR = 22'h3F_FFFE; // device id pair
	localparam logic [3:0]  CPAG_CFG_MODE  = 4'h6;        // lvp and debug
	localparam logic [3:0]  CPAG_CFG_CP_L  = 4'h8;
	localparam logic [3:0]  CPAG_CFG_CP_H  = 4'h9;
	localparam logic [3:0]  CPAG_CFG_WR_L  = 4'hA;
	localparam logic [3:0]  CPAG_CFG_WR_H  = 4'hB;
	localparam logic [3:0]  CPAG_CFG_EB_L  = 4'hC;
	localparam logic [3:0]  CPAG_CFG_EB_H  = 4'hD;
	localparam int          CPAG_LVP_POS   = 2;           // in mode byte
	localparam int          CPAG_DBG_POS   = 7;           // in mode byte
	localparam logic [2:0]  CPAG_BOOT_IDX  = 3'h4;        // boot block
	localparam logic [2:0]  CPAG_UNIMP_IDX = 3'h7;        // beyond memory
	// ************
	// apb registers
	// ************
	localparam logic [7:0]  CPAG_PROT_STATE = 8'h00; // ro
	localparam logic [7:0]  CPAG_MODE_STATE = 8'h04; // ro
	localparam logic [7:0]  CPAG_MEM_SIZE   = 8'h08; // rw
	localparam logic [7:0]  CPAG_REFUSE_CNT = 8'h0C; // ro
	localparam logic [1:0]  CPAG_SIZE_RST   = 2'h2;  // 32 kbyte
	// ************
	// debugger reservations
	// ************
	localparam logic [4:0]  CPAG_DBG_STACK = 5'h2;   // stack levels
	localparam int          CPAG_DBG_PROG  = 512;    // program bytes
	localparam int          CPAG_DBG_DATA  = 10;     // data bytes
	// ************
	// types
	// ************
	typedef enum logic [2:0] {CPAG_OP_READ, CPAG_OP_WRITE, CPAG_OP_ROW_ERASE,
		CPAG_OP_BLOCK_ERASE, CPAG_OP_CHIP_ERASE} cpag_op_type;
	typedef enum logic [1:0] {CPAG_SRC_MEM, CPAG_SRC_CFG, CPAG_SRC_DEVID,
		CPAG_SRC_ZERO} cpag_src_type;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        eeprom;
		logic [21:0] addr;
		logic [21:0] pc;
		logic [7:0]  wdata;
	} cpag_cpu_req_type;
	typedef struct packed {
		logic        valid;
		cpag_op_type op;
		logic        eeprom;
		logic [21:0] addr;
		logic [7:0]  wdata;
	} cpag_ext_req_type;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        eeprom;
		logic        row_erase;
		logic        blk_erase;
		logic        chip_erase;
		logic [2:0]  blk;
		logic [21:0] addr;
		logic [7:0]  wdata;
	} cpag_mem_cmd_type;
	typedef struct packed {
		logic       valid;
		logic       refused;
		logic [7:0] data;
	} cpag_resp_type;
endpackage : cpag_pkg
`default_nettype wire

/* File: verilog/cpag_gate.sv */
// module: table access gate with protection bits, mode entry and apb
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cpag_gate
#(
	parameter int          STACK_DEPTH = 16,          // hardware stack levels
	parameter logic [15:0] DEVID_WORD  = 16'h1234     // arbitrary id value
)
(
	input  wire logic                      clock,
	input  wire logic                      arst_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic                      pready,
	output var  logic [31:0]               prdata,
	output var  logic                      pslverr,
	input  wire cpag_pkg::cpag_cpu_req_type cpu_req,
	input  wire cpag_pkg::cpag_ext_req_type ext_req,
	output var  cpag_pkg::cpag_mem_cmd_type mem_cmd,
	input  wire logic [7:0]                mem_rdata,
	output var  cpag_pkg::cpag_resp_type    resp,
	input  wire logic                      high_prog_voltage,
	input  wire logic                      prog_entry_pin,
	input  wire logic                      gpio_out,
	input  wire logic                      gpio_oe,
	output var  logic                      prog_entry_shared_pin_out,
	output var  logic                      prog_entry_shared_pin_oe,
	output var  logic                      prog_mode,
	output var  logic                      debug_active,
	output var  logic                      debug_pins_reserved,
	output var  logic [4:0]                usable_stack
);
	import cpag_pkg::*;

	// ************
	// state
	// ************
	logic [4:0]   cp;        // block_read_lock, bit4 boot
	logic [4:0]   wrt;       // block_write_lock
	logic [4:0]   ebtr;      // block_foreign_read_lock
	logic         data_mem_read_lock;       // data_mem_read_lock
	logic         data_mem_write_lock;      // data_mem_write_lock
	logic         config_write_lock;      // config_write_lock
	logic         single_supply_prog_enable;       // single_supply_prog_enable
	logic         dbg_n;     // debugger enable, low active
	logic         hv_mode;   // high voltage entry seen
	logic [1:0]   mem_size;  // 8k shl n
	logic [15:0]  refuse_cnt; // refused accesses
	logic         pend;      // response due next cycle
	logic         pend_ref;  // pending refusal
	cpag_src_type pend_src;  // pending data source
	logic [7:0]   pend_cfg;  // pending config byte

	// ************
	// decision terms
	// ************
	logic         use_ext;   // programmer owns this cycle
	logic         take;      // a request is taken
	logic [21:0]  a;         // request address
	logic [2:0]   blk;       // target block
	logic [2:0]   pc_blk;    // block of fetching code
	logic         is_id;
	logic         is_cfg;
	logic         is_devid;
	logic         next_ref;
	logic         next_cfg_we;
	logic         next_blk_er;
	logic         next_chip_er;
	cpag_src_type next_src;
	cpag_mem_cmd_type next_cmd;

	// block index of an address for the chosen memory size
	function automatic logic [2:0] blk_of(input logic [21:0] ad,
		input logic [1:0] sz);
		logic [21:0] lim;
		logic [21:0] boot;
		logic [21:0] idx;
		lim  = 22'h00_2000 << sz;
		boot = (sz == 2'h0) ? 22'h00_0200 : 22'h00_0800;
		idx  = (sz == 2'h0) ? (ad >> 12) : (sz == 2'h3) ? (ad >> 14)
			: (ad >> 13);
		if (ad >= lim)
			blk_of = CPAG_UNIMP_IDX;
		else if (ad < boot)
			blk_of = CPAG_BOOT_IDX;
		else
			blk_of = idx[2:0];
	endfunction : blk_of

	// config byte image at a low address nibble
	function automatic logic [7:0] cfg_byte(input logic [3:0] lo);
		cfg_byte = 8'h00;
		if (lo == CPAG_CFG_MODE)
		begin
			cfg_byte[CPAG_LVP_POS] = single_supply_prog_enable;
			cfg_byte[CPAG_DBG_POS] = dbg_n;
		end
		else if (lo == CPAG_CFG_CP_L)
			cfg_byte = {4'h0, cp[3:0]};
		else if (lo == CPAG_CFG_CP_H)
			cfg_byte = {data_mem_read_lock, cp[4], 6'h00};
		else if (lo == CPAG_CFG_WR_L)
			cfg_byte = {4'h0, wrt[3:0]};
		else if (lo == CPAG_CFG_WR_H)
			cfg_byte = {data_mem_write_lock, wrt[4], config_write_lock, 5'h00};
		else if (lo == CPAG_CFG_EB_L)
			cfg_byte = {4'h0, ebtr[3:0]};
		else if (lo == CPAG_CFG_EB_H)
			cfg_byte = {1'b0, ebtr[4], 6'h00};
	endfunction : cfg_byte

	// ************
	// access decision
	// ************
	assign use_ext  = prog_mode && ext_req.valid;
	assign take     = use_ext || (!prog_mode && cpu_req.valid);
	assign a        = use_ext ? ext_req.addr : cpu_req.addr;
	assign blk      = blk_of(a, mem_size);
	assign pc_blk   = blk_of(cpu_req.pc, mem_size);
	assign is_id    = a[21:3] == CPAG_ID_BASE[21:3];
	assign is_cfg   = a[21:4] == CPAG_CFG_BASE[21:4];
	assign is_devid = a[21:1] == CPAG_DEVID_ADR[21:1];

	// decide what reaches memory and what comes back
	always_comb
	begin
		next_cmd     = '0;
		next_src     = CPAG_SRC_ZERO;
		next_ref     = 1'b0;
		next_cfg_we  = 1'b0;
		next_blk_er  = 1'b0;
		next_chip_er = 1'b0;
		next_cmd.addr   = a;
		next_cmd.wdata  = use_ext ? ext_req.wdata : cpu_req.wdata;
		next_cmd.blk    = blk;
		next_cmd.eeprom = use_ext ? ext_req.eeprom : cpu_req.eeprom;
		if (!take)
			next_cmd.eeprom = 1'b0;
		// programmer erases
		else if (use_ext && ext_req.op == CPAG_OP_CHIP_ERASE)
		begin
			next_cmd.chip_erase = 1'b1;
			next_chip_er        = 1'b1;
		end
		else if (use_ext && ext_req.op == CPAG_OP_BLOCK_ERASE)
		begin
			next_cmd.blk_erase = blk != CPAG_UNIMP_IDX;
			next_blk_er        = blk != CPAG_UNIMP_IDX;
			next_ref           = blk == CPAG_UNIMP_IDX;
		end
		else if (use_ext && ext_req.op == CPAG_OP_ROW_ERASE)
		begin
			next_ref = blk == CPAG_UNIMP_IDX || !cp[blk];
			next_cmd.row_erase = !next_ref;
		end
		// eeprom data memory
		else if (next_cmd.eeprom)
		begin
			if (use_ext && !data_mem_read_lock)
				next_ref = 1'b1;
			else if ((use_ext ? ext_req.op == CPAG_OP_WRITE
				: cpu_req.write) && !data_mem_write_lock)
				next_ref = 1'b1;
			next_src = next_ref ? CPAG_SRC_ZERO : CPAG_SRC_MEM;
			next_cmd.wr = !next_ref && (use_ext ?
				ext_req.op == CPAG_OP_WRITE : cpu_req.write);
			next_cmd.rd = !next_ref && !next_cmd.wr;
		end
		// program space writes
		else if (use_ext ? ext_req.op == CPAG_OP_WRITE : cpu_req.write)
		begin
			if (is_cfg)
			begin
				next_ref    = !use_ext && !config_write_lock;
				next_cfg_we = !next_ref;
			end
			else if (is_id)
				next_cmd.wr = 1'b1;
			else if (is_devid || blk == CPAG_UNIMP_IDX)
				next_ref = 1'b1;
			else if (use_ext)
			begin
				next_ref    = !cp[blk];
				next_cmd.wr = cp[blk];
			end
			else
			begin
				next_ref    = !wrt[blk];
				next_cmd.wr = wrt[blk];
			end
		end
		// program space reads
		else if (is_cfg)
			next_src = CPAG_SRC_CFG;
		else if (is_devid)
			next_src = CPAG_SRC_DEVID;
		else if (is_id)
		begin
			next_cmd.rd = 1'b1;
			next_src    = CPAG_SRC_MEM;
		end
		else if (blk == CPAG_UNIMP_IDX)
			next_src = CPAG_SRC_ZERO;
		else if (use_ext)
		begin
			next_ref    = !cp[blk];
			next_cmd.rd = cp[blk];
			next_src    = cp[blk] ? CPAG_SRC_MEM : CPAG_SRC_ZERO;
		end
		else
		begin
			next_ref = !ebtr[blk] && pc_blk != blk;
			next_cmd.rd = !next_ref;
			next_src = next_ref ? CPAG_SRC_ZERO : CPAG_SRC_MEM;
		end
	end

	// ************
	// protection bits
	// ************
	// chip and block erases set bits; writes only clear them, except mode byte writes, which load dbg_n, and single_supply_prog_enable only in high voltage mode
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cp    <= '1;
			wrt   <= '1;
			ebtr  <= '1;
			data_mem_read_lock   <= 1'b1;
			data_mem_write_lock  <= 1'b1;
			config_write_lock  <= 1'b1;
			single_supply_prog_enable   <= 1'b1;
			dbg_n <= 1'b1;
		end
		else if (next_chip_er)
		begin
			cp    <= '1;
			wrt   <= '1;
			ebtr  <= '1;
			data_mem_read_lock   <= 1'b1;
			data_mem_write_lock  <= 1'b1;
			config_write_lock  <= 1'b1;
			single_supply_prog_enable   <= 1'b1;
			dbg_n <= 1'b1;
		end
		else if (next_blk_er)
		begin
			cp[blk]   <= 1'b1;
			wrt[blk]  <= 1'b1;
			ebtr[blk] <= 1'b1;
		end
		else if (next_cfg_we)
		begin
			if (a[3:0] == CPAG_CFG_MODE)
			begin
				dbg_n <= next_cmd.wdata[CPAG_DBG_POS];
				if (hv_mode)
					single_supply_prog_enable <= next_cmd.wdata[CPAG_LVP_POS];
			end
			else if (a[3:0] == CPAG_CFG_CP_L)
				cp[3:0] <= cp[3:0] & next_cmd.wdata[3:0];
			else if (a[3:0] == CPAG_CFG_CP_H)
			begin
				data_mem_read_lock   <= data_mem_read_lock & next_cmd.wdata[7];
				cp[4] <= cp[4] & next_cmd.wdata[6];
			end
			else if (a[3:0] == CPAG_CFG_WR_L)
				wrt[3:0] <= wrt[3:0] & next_cmd.wdata[3:0];
			else if (a[3:0] == CPAG_CFG_WR_H)
			begin
				data_mem_write_lock   <= data_mem_write_lock & next_cmd.wdata[7];
				wrt[4] <= wrt[4] & next_cmd.wdata[6];
				if (use_ext)
					config_write_lock <= config_write_lock & next_cmd.wdata[5];
			end
			else if (a[3:0] == CPAG_CFG_EB_L)
				ebtr[3:0] <= ebtr[3:0] & next_cmd.wdata[3:0];
			else if (a[3:0] == CPAG_CFG_EB_H)
				ebtr[4] <= ebtr[4] & next_cmd.wdata[6];
		end
	end

	// ************
	// pipeline and answer
	// ************
	// stage one: memory command and pending answer
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mem_cmd  <= '0;
			pend     <= 1'b0;
			pend_ref <= 1'b0;
			pend_src <= CPAG_SRC_ZERO;
			pend_cfg <= 8'h00;
		end
		else
		begin
			mem_cmd  <= next_cmd;
			pend     <= take;
			pend_ref <= next_ref;
			pend_src <= next_src;
			pend_cfg <= cfg_byte(a[3:0]);
		end
	end

	// stage two: answer with data picked by source
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			resp <= '0;
		else
		begin
			resp.valid   <= pend;
			resp.refused <= pend && pend_ref;
			case (pend_src)
				CPAG_SRC_MEM:   resp.data <= mem_rdata;
				CPAG_SRC_CFG:   resp.data <= pend_cfg;
				CPAG_SRC_DEVID: resp.data <= mem_cmd.addr[0] ?
					DEVID_WORD[15:8] : DEVID_WORD[7:0];
				default:        resp.data <= 8'h00;
			endcase
		end
	end

	// count refusals, saturating
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			refuse_cnt <= 16'h0000;
		else if (take && next_ref && refuse_cnt != 16'hFFFF)
			refuse_cnt <= refuse_cnt + 16'h0001;
	end

	// ************
	// mode entry and pins
	// ************
	// entry by high voltage or by pin under single supply
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hv_mode   <= 1'b0;
			prog_mode <= 1'b0;
		end
		else
		begin
			hv_mode   <= high_prog_voltage;
			prog_mode <= high_prog_voltage
				|| (single_supply_prog_enable && prog_entry_pin);
		end
	end

	// shared pin given to gpio only without single supply
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prog_entry_shared_pin_out <= 1'b0;
			prog_entry_shared_pin_oe  <= 1'b0;
		end
		else
		begin
			prog_entry_shared_pin_out <= gpio_out && !single_supply_prog_enable;
			prog_entry_shared_pin_oe  <= gpio_oe && !single_supply_prog_enable;
		end
	end

	// debugger claims pins and stack when enabled
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			debug_active        <= 1'b0;
			debug_pins_reserved <= 1'b0;
			usable_stack        <= 5'(STACK_DEPTH);
		end
		else
		begin
			debug_active        <= !dbg_n;
			debug_pins_reserved <= !dbg_n;
			usable_stack        <= dbg_n ? 5'(STACK_DEPTH)
				: 5'(STACK_DEPTH) - CPAG_DBG_STACK;
		end
	end

	// ************
	// apb slave
	// ************
	// one wait state, answer on second access cycle
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready   <= 1'b0;
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
			mem_size <= CPAG_SIZE_RST;
		end
		else if (psel && penable && !pready)
		begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (paddr == CPAG_PROT_STATE)
				prdata[19:0] <= {dbg_n, single_supply_prog_enable, config_write_lock, data_mem_write_lock, data_mem_read_lock, ebtr, wrt, cp};
			else if (paddr == CPAG_MODE_STATE)
				prdata[3:0] <= {!dbg_n, single_supply_prog_enable, hv_mode, prog_mode};
			else if (paddr == CPAG_MEM_SIZE)
			begin
				prdata[1:0] <= mem_size;
				if (pwrite)
					mem_size <= pwdata[1:0];
			end
			else if (paddr == CPAG_REFUSE_CNT)
				prdata[15:0] <= refuse_cnt;
			else
				pslverr <= 1'b1;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ************
	// checks
	// ************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	logic [17:0]  prot_bits; // every protection bit except single_supply_prog_enable and dbg_n, for rise checks
	assign prot_bits = {cp, wrt, ebtr, data_mem_read_lock, data_mem_write_lock, config_write_lock};

	sequence s_cpu_rd;
		!prog_mode && cpu_req.valid && !cpu_req.write && !cpu_req.eeprom
		&& !is_cfg && !is_id && !is_devid && blk != CPAG_UNIMP_IDX;
	endsequence
	sequence s_cpu_wr;
		!prog_mode && cpu_req.valid && cpu_req.write && !cpu_req.eeprom
		&& !is_cfg && !is_id && !is_devid && blk != CPAG_UNIMP_IDX;
	endsequence

	foreign_read_zero_a: assert property (
		s_cpu_rd ##0 (!ebtr[blk] && pc_blk != blk) |=> !mem_cmd.rd ##1 resp.valid && resp.data == 8'h00)
		else $error("foreign locked read not zeroed");
	own_block_read_a: assert property (
		s_cpu_rd ##0 pc_blk == blk |=> mem_cmd.rd ##1 resp.valid && !resp.refused)
		else $error("own block read refused");
	write_lock_block_a: assert property (
		s_cpu_wr ##0 !wrt[blk] |=> !mem_cmd.wr ##1 resp.refused)
		else $error("locked block write reached memory");
	eeprom_cpu_read_a: assert property (
		!prog_mode && cpu_req.valid && cpu_req.eeprom && !cpu_req.write |=> mem_cmd.rd)
		else $error("cpu eeprom read blocked");
	eeprom_write_lock_a: assert property (
		take && next_cmd.eeprom && !data_mem_write_lock |=> !mem_cmd.wr)
		else $error("eeprom write under lock");
	eeprom_ext_lock_a: assert property (
		use_ext && ext_req.eeprom && !data_mem_read_lock && (ext_req.op == CPAG_OP_READ || ext_req.op == CPAG_OP_WRITE)
		|=> !mem_cmd.rd && !mem_cmd.wr ##1 resp.refused)
		else $error("external eeprom access under lock");
	bits_rise_erase_a: assert property (
		|(prot_bits & ~$past(prot_bits)) |-> $past(next_chip_er) || $past(next_blk_er))
		else $error("protection bit set without erase");
	entry_pin_owned_a: assert property (single_supply_prog_enable [*2] |-> !prog_entry_shared_pin_oe)
		else $error("entry pin driven as gpio");
	hv_entry_a: assert property (high_prog_voltage |=> prog_mode)
		else $error("high voltage entry ignored");
	id_read_a: assert property (
		!prog_mode && cpu_req.valid && is_id && !cpu_req.write && !cpu_req.eeprom |=> mem_cmd.rd)
		else $error("id read blocked");
endmodule : cpag_gate
`default_nettype wire

/* File: dv/cpag_prog_model.sv */
// partner model: external programmer driving table requests and mode entry
`timescale 1ns/1ns
`default_nettype none
module cpag_prog_model
(
	input  wire logic                       clock,
	output var  cpag_pkg::cpag_ext_req_type ext_req,
	output var  logic                       high_prog_voltage,
	output var  logic                       prog_entry_pin
);
	import cpag_pkg::*;
	// idle: no request, no entry
	initial
	begin
		ext_req = '0;
		high_prog_voltage = 1'b0;
		prog_entry_pin = 1'b0;
	end
	// mode entry by high voltage or by the entry pin
	task automatic enter(input bit hv);
		@(posedge clock);
		if (hv)
			high_prog_voltage <= 1'b1;
		else
			prog_entry_pin <= 1'b1;
	endtask : enter
	// back to normal run, entry pin held low
	task automatic leave();
		@(posedge clock);
		high_prog_voltage <= 1'b0;
		prog_entry_pin <= 1'b0;
	endtask : leave
	// one request for one cycle; erases start only here, lock changes also come from cpu writes while config_write_lock is set
	task automatic send(input int op, input bit eep, input logic [21:0] a, input logic [7:0] d);
		@(posedge clock);
		ext_req <= '{1'b1, cpag_op_type'(op), eep, a, d};
		@(posedge clock);
		ext_req <= '{1'b0, cpag_op_type'(op), eep, ~a, ~d}; // released lines show garbage
	endtask : send
endmodule : cpag_prog_model
`default_nettype wire

/* File: dv/tb.sv */
// testbench: access gate against a reference model of the protection bits
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cpag_pkg::*;
	localparam logic [15:0] DEVID = 16'hA5C3; // arbitrary id value
	localparam logic [11:0] CFG [7] = '{12'h8FE, 12'hCFE, 12'hAFD, 12'hB00, 12'h97F, 12'hCFF, 12'h67B};
	logic             clock, arst_n, psel, penable, pwrite, gpio_out, gpio_oe;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, rnd;
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, hv, pgm_drv, pin_out, pin_oe, prog_mode, debug_active, debug_pins;
	wire logic [4:0]  usable_stack;
	cpag_cpu_req_type cpu_req;
	cpag_ext_req_type ext_req;
	cpag_mem_cmd_type mem_cmd;
	cpag_resp_type    resp;
	logic [19:0]      pb;        // model protection bits
	int               msz;       // model memory size code
	int               error_cnt, checked, i;
	wire logic [7:0]  mem_rdata = mem_cmd.addr[7:0] ^ 8'h5A; // memory stand-in
	wire logic        pin_level = pin_oe ? pin_out : pgm_drv;  // shared pin wire
	cpag_gate #(.STACK_DEPTH(16), .DEVID_WORD(DEVID)) i_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cpu_req(cpu_req), .ext_req(ext_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata),
		.resp(resp), .high_prog_voltage(hv), .prog_entry_pin(pin_level), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .prog_entry_shared_pin_out(pin_out), .prog_entry_shared_pin_oe(pin_oe),
		.prog_mode(prog_mode), .debug_active(debug_active), .debug_pins_reserved(debug_pins),
		.usable_stack(usable_stack));
	cpag_prog_model i_prog (.clock(clock), .ext_req(ext_req), .high_prog_voltage(hv), .prog_entry_pin(pgm_drv));
	// ************
	// model and checks
	// ************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// block index of a program address under the model's memory size
	function automatic int blk(input logic [21:0] a);
		if (a >= (22'h00_2000 << msz))
			return 7;
		if (a < (msz == 0 ? 22'h00_0200 : 22'h00_0800))
			return 4;
		return msz == 0 ? int'(a >> 12) : msz == 3 ? int'(a >> 14) : int'(a >> 13);
	endfunction : blk
	// expected config byte image from the model bits
	function automatic logic [7:0] cfg_img(input logic [3:0] lo);
		case (lo)
			4'h6: return {pb[19], 4'h0, pb[18], 2'h0};
			4'h8: return {4'h0, pb[3:0]};
			4'h9: return {pb[15], pb[4], 6'h00};
			4'hA: return {4'h0, pb[8:5]};
			4'hB: return {pb[16], pb[9], pb[17], 5'h00};
			4'hC: return {4'h0, pb[13:10]};
			4'hD: return {1'b0, pb[14], 6'h00};
			default: return 8'h00;
		endcase
	endfunction : cfg_img
	// expected {refused, data}; updates the model bits
	function automatic logic [8:0] ref_rsp(input bit ext, input int op, input bit eep, input logic [21:0] a, pc,
		input logic [7:0] d);
		int          b;
		logic [19:0] k;
		b = blk(a);
		k = '1;
		if (eep)
			return {(ext && !pb[15]) || (op == 1 && !pb[16]), a[7:0] ^ 8'h5A};
		if (a >= 22'h3F_FFFE)
			return {op != 0, a[0] ? DEVID[15:8] : DEVID[7:0]};
		if (a[21:4] == 18'h3_0000)
		begin
			if (op == 0)
				return {1'b0, cfg_img(a[3:0])};
			if (!ext && !pb[17])
				return 9'h100;
			case (a[3:0])
				4'h6: k[19:18] = {d[7], d[2] | !hv};
				4'h8: k[3:0] = d[3:0];
				4'h9: {k[15], k[4]} = d[7:6];
				4'hA: k[8:5] = d[3:0];
				4'hB: {k[16], k[9], k[17]} = d[7:5];
				4'hC: k[13:10] = d[3:0];
				4'hD: k[14] = d[6];
				default: k = '1;
			endcase
			pb &= k;
			return 9'h000;
		end
		if (a[21:3] == 19'h4_0000)
			return {1'b0, a[7:0] ^ 8'h5A};
		if (op == 4)
			pb = '1;
		if (op == 3)
			pb = pb | (20'h0_0421 << b);
		if (op > 2)
			return 9'h000;
		if (b == 7)
			return {op != 0, 8'h00};
		if (op == 0)
			return {ext ? !pb[b] : !pb[10 + b] && blk(pc) != b, a[7:0] ^ 8'h5A};
		return {ext ? !pb[b] : op == 1 && !pb[5 + b], 8'h00};
	endfunction : ref_rsp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// apb transfer: setup, access, wait for pready
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] wd, exp, input bit err);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 16 && pready !== 1'b1; n++)
			@(posedge clock);
		chk(pready, 1);
		if (!w)
			chk(prdata, exp);
		chk(pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one table access from cpu or programmer, checked against the model
	task automatic acc(input bit ext, input int op, input bit eep, input logic [21:0] a, pc, input logic [7:0] d);
		logic [8:0]  e;
		bit          wr;
		logic [2:0]  er;
		logic [29:0] wd;
		int          n;
		e = ref_rsp(ext, op, eep, a, pc, d);
		wr = 1'b0;
		er = 3'h0;
		wd = '0;
		if (ext)
			i_prog.send(op, eep, a, d);
		else
		begin
			@(posedge clock);
			cpu_req <= '{1'b1, op == 1, eep, a, pc, d};
			@(posedge clock);
			cpu_req <= '{1'b0, 1'b0, eep, ~a, ~pc, ~d};
		end
		for (n = 0; n < 4 && resp.valid !== 1'b1; n++)
		begin
			@(posedge clock);
			wr |= mem_cmd.wr === 1'b1;
			er |= {mem_cmd.chip_erase, mem_cmd.blk_erase, mem_cmd.row_erase};
			if (mem_cmd.wr === 1'b1)
				wd = {mem_cmd.addr, mem_cmd.wdata};
		end
		chk(resp.valid, 1);
		chk({resp.refused, resp.data & {8{op == 0}}}, {e[8], e[7:0] & {8{op == 0 && !e[8]}}});
		chk(er, op > 1 && !e[8] ? 3'h1 << (op - 2) : 3'h0);
		if (op == 1 && a[21:20] != 2'h3)
		begin
			chk(wr, !e[8]);
			chk(wd, e[8] ? 30'h0 : {a, d});
		end
	endtask : acc
	task automatic wm(input logic v);
		int n;
		for (n = 0; n < 20 && prog_mode !== v; n++)
			@(posedge clock);
		chk(prog_mode, v);
	endtask : wm
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// ************
	// clock, watchdog, tests
	// ************
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial
	begin
		#200000;
		error_cnt++;
		final_report();
	end
	initial
	begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		cpu_req = '0;
		{gpio_out, gpio_oe} = 2'h3;
		pb = '1;
		msz = 2;
		rnd = 32'h3789_32ec;
		{error_cnt, checked} = '0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk(pin_oe, 0);
		chk(usable_stack, 16);
		apb(0, CPAG_PROT_STATE, 0, {12'h000, pb}, 0);
		apb(0, CPAG_MODE_STATE, 0, 32'h0000_0004, 0);
		apb(1, CPAG_MEM_SIZE, 32'h0000_0003, 0, 0);
		msz = 3;
		acc(0, 0, 0, 22'h00_C100, 22'h00_0100, 0);
		apb(1, CPAG_MEM_SIZE, 32'h0000_0000, 0, 0);
		msz = 0;
		acc(0, 1, 0, 22'h00_4100, 22'h00_0100, 8'h66);
		apb(1, CPAG_MEM_SIZE, 32'h0000_0002, 0, 0);
		msz = 2;
		apb(0, CPAG_MEM_SIZE, 0, 32'h0000_0002, 0);
		apb(0, 8'h10, 0, 0, 1);
		acc(0, 0, 0, 22'h00_2100, 22'h00_0100, 0);
		acc(0, 0, 0, 22'h20_0003, 22'h00_0100, 0);
		acc(0, 0, 0, 22'h3F_FFFF, 22'h00_0100, 0);
		acc(0, 1, 0, 22'h00_9000, 22'h00_0100, 8'h11);
		$display("test reset and plain access done");
		i_prog.enter(0);
		wm(1);
		for (i = 0; i < 7; i++)
			acc(1, 1, 0, {18'h3_0000, CFG[i][11:8]}, 0, CFG[i][7:0]);
		apb(0, CPAG_PROT_STATE, 0, {12'h000, pb}, 0);
		for (i = 0; i < 7; i++)
			acc(1, 0, 0, {18'h3_0000, CFG[i][11:8]}, 0, 0);
		acc(1, 0, 0, 22'h00_0900, 0, 0);
		acc(1, 0, 1, 22'h00_0010, 0, 0);
		acc(1, 1, 1, 22'h00_0010, 0, 8'h22);
		acc(1, 0, 0, 22'h20_0005, 0, 0);
		acc(1, 2, 0, 22'h00_0900, 0, 0);
		acc(1, 2, 0, 22'h00_4100, 0, 0);
		i_prog.leave();
		wm(0);
		$display("test lock setting done");
		chk({debug_active, debug_pins, usable_stack}, 7'h6E);
		acc(0, 0, 0, 22'h00_0900, 22'h00_2000, 0);
		acc(0, 0, 0, 22'h00_0900, 22'h00_0A00, 0);
		acc(0, 1, 0, 22'h00_2100, 22'h00_0100, 8'h33);
		acc(0, 1, 0, 22'h00_4100, 22'h00_0100, 8'h44);
		acc(0, 0, 1, 22'h00_0010, 22'h00_0100, 0);
		acc(0, 1, 1, 22'h00_0010, 22'h00_0100, 8'h55);
		acc(0, 1, 0, 22'h30_0008, 22'h00_0100, 8'h00);
		acc(0, 0, 0, 22'h30_0009, 22'h00_0100, 0);
		for (i = 0; i < 12; i++)
		begin
			rnd = lfsr(rnd);
			acc(0, 0, 0, {6'h00, rnd[15:0]} & 22'h00_9FFF, {7'h00, rnd[30:16]}, 0);
			acc(0, 1, 0, {19'h4_0000, rnd[2:0]}, 22'h00_0100, rnd[7:0]);
		end
		apb(0, CPAG_PROT_STATE, 0, {12'h000, pb}, 0);
		$display("test gated cpu access done");
		i_prog.enter(1);
		wm(1);
		acc(1, 3, 0, 22'h00_0900, 0, 0);
		acc(1, 2, 0, 22'h00_0900, 0, 0);
		acc(1, 1, 0, 22'h30_0006, 0, 8'h7B);
		apb(0, CPAG_PROT_STATE, 0, {12'h000, pb}, 0);
		i_prog.leave();
		wm(0);
		gpio_out <= 1'b0;
		repeat (3) @(posedge clock);
		chk({pin_oe, pin_out}, 2'h2);
		gpio_oe <= 1'b0;
		i_prog.enter(0);
		repeat (10) @(posedge clock);
		chk(prog_mode, 0);
		i_prog.leave();
		$display("test high voltage session done");
		i_prog.enter(1);
		wm(1);
		acc(1, 4, 0, 22'h00_0000, 0, 0);
		apb(0, CPAG_PROT_STATE, 0, {12'h000, pb}, 0);
		i_prog.leave();
		$display("test chip erase done");
		final_report();
	end
endmodule : tb
`default_nettype wire
